/* rtl/utb_pkg.sv */
// Purpose : Constants and types for the one-channel up-count timer base.
// Assumes : Classic Wishbone with 32-bit data and byte addresses.
// Notes   : Register offsets are byte addresses, one aligned word each.

// ----------------------------------------
// Package
// ----------------------------------------
package utb_pkg;

  localparam int CNT_W = 16;
  localparam int ADR_W = 8;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] OFS_CTL0   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_INTEN  = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_INTF   = 8'h10;
  localparam logic [ADR_W-1:0] OFS_SWEVG  = 8'h14;
  localparam logic [ADR_W-1:0] OFS_INTCLR = 8'h18;
  localparam logic [ADR_W-1:0] OFS_CNT    = 8'h24;
  localparam logic [ADR_W-1:0] OFS_PSC    = 8'h28;
  localparam logic [ADR_W-1:0] OFS_CAR    = 8'h2C;

  // Field positions.
  localparam int CTL_CEN_BIT   = 0;
  localparam int CTL_UPDATE_DISABLE_BIT_BIT = 1;
  localparam int EVG_UPG_BIT   = 0;
  localparam int EVG_CHG_BIT   = 1;
  localparam int INT_UP_BIT    = 0;
  localparam int INT_CH_BIT    = 1;
  localparam int INT_W         = 2;

  // Reset values and the count step.
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
  localparam logic [CNT_W-1:0] RST_PSC = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CAR = 16'hFFFF;
  localparam logic [CNT_W-1:0] ONE_CNT = 16'h0001;
  localparam logic [31:0]      ZERO_W  = 32'h0000_0000;

  // Wishbone request carrier.
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } utb_wb_req_type;

endpackage

/* rtl/utb_timer.sv */
// Purpose : 16-bit up-only timer base with prescaler, auto-reload and update events.
// Assumes : Single clock; the kernel timer clock is clk_i; synchronous reset.
// Notes   : Wishbone slave answers every access one cycle after the strobe.
// Operation
// - Sixteen-bit unsigned counter counting upward only.
// - Prescaler runs from kernel clock when enabled.
// - Prescale value N divides by N plus one.
// - New prescale value applies at next update.
// - Count from zero to reload value, wrap.
// - Overflow raises an update event unless disabled.
// - Force-update bit clears counter, issues update.
// - Update-disable bit suppresses updates and shadow transfers.
// - Update copies pending reload and prescale values.
// - Interrupt output covers update and channel events.
//
// Implementation choices: the Wishbone interface to the registers and the address map.

`timescale 1ns/1ps
`default_nettype none

module utb_timer
  import utb_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Channel event from the capture/compare logic.
  input  wire logic             chan_event_i,
  // Timer outputs.
  output logic                  update_o,
  output logic      [CNT_W-1:0] count_o,
  output logic                  irq_o
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  utb_wb_req_type req;
  logic           ack;
  logic [31:0]    rdata;

  // Pack the request so decode reads from one carrier.
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // Merges write data into a 16-bit field under the byte enables.
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
    logic [CNT_W-1:0] r;
    r = old_v;
    if (sel[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // A request is taken while ack is low. A write lands on the edge where the master
  // samples ack, so the master and the registers agree on when it happened.
  wire access = req.cyc && req.stb && !ack;
  wire wr     = req.cyc && req.stb && req.we && ack;
  wire wr_lo  = wr && req.sel[0];
  wire wr_ctl = wr_lo && (req.adr == OFS_CTL0);
  wire wr_ien = wr_lo && (req.adr == OFS_INTEN);
  wire wr_clr = wr_lo && (req.adr == OFS_INTCLR);
  wire wr_evg = wr_lo && (req.adr == OFS_SWEVG);
  wire wr_cnt = wr && (req.adr == OFS_CNT);
  wire wr_psc = wr && (req.adr == OFS_PSC);
  wire wr_car = wr && (req.adr == OFS_CAR);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic             count_enable_bit;
  logic             update_disable_bit;
  logic [INT_W-1:0] int_en;
  logic [INT_W-1:0] int_flag;
  logic [CNT_W-1:0] prescale_value;   // Preload stage written by software.
  logic [CNT_W-1:0] psc_shadow;       // Active divider value.
  logic [CNT_W-1:0] reload_pending;   // Preload stage of the reload limit.
  logic [CNT_W-1:0] reload_shadow;    // Active reload limit.
  logic [CNT_W-1:0] psc_cnt;
  logic [CNT_W-1:0] cnt;

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  // The divided count tick fires when the prescaler has run through N+1 kernel clocks.
  wire force_update_bit = wr_evg && req.dat[EVG_UPG_BIT];
  wire chan_soft        = wr_evg && req.dat[EVG_CHG_BIT];
  wire divided_count_clock = count_enable_bit && (psc_cnt == psc_shadow);
  wire overflow = divided_count_clock && (cnt >= reload_shadow);
  // Both overflow and the forced update are gated by the disable bit; the forced
  // update still restarts the counter so software can resynchronise the period.
  wire update_ev = (overflow || force_update_bit) && !update_disable_bit;

  // Next counter value; a forced update wins over counting.
  wire [CNT_W-1:0] next_cnt =
      force_update_bit    ? RST_CNT :
      wr_cnt              ? merge16(cnt, req.dat, req.sel) :
      overflow            ? RST_CNT :
      divided_count_clock ? cnt + ONE_CNT :
                            cnt;

  // Prescaler counter restarts on a tick or any forced update.
  wire [CNT_W-1:0] next_psc_cnt =
      (force_update_bit || divided_count_clock) ? RST_CNT :
      count_enable_bit ? psc_cnt + ONE_CNT : psc_cnt;

  // Sticky flags; a new event wins over a software clear in the same cycle.
  wire [INT_W-1:0] ev_vec;
  assign ev_vec[INT_UP_BIT] = update_ev;
  assign ev_vec[INT_CH_BIT] = chan_event_i || chan_soft;
  wire [INT_W-1:0] clr_vec = wr_clr ? req.dat[INT_W-1:0] : '0;
  wire [INT_W-1:0] next_int_flag = (int_flag & ~clr_vec) | ev_vec;

  // Counter and prescaler state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= RST_CNT;
      psc_cnt <= RST_CNT;
    end else begin
      cnt     <= next_cnt;
      psc_cnt <= next_psc_cnt;
    end
  end

  // Shadow transfers happen only on a real update event.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_shadow    <= RST_PSC;
      reload_shadow <= RST_CAR;
    end else if (update_ev) begin
      psc_shadow    <= prescale_value;
      reload_shadow <= reload_pending;
    end
  end

  // Software registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_enable_bit   <= 1'b0;
      update_disable_bit <= 1'b0;
      int_en             <= '0;
      prescale_value     <= RST_PSC;
      reload_pending     <= RST_CAR;
    end else begin
      if (wr_ctl) begin
        count_enable_bit   <= req.dat[CTL_CEN_BIT];
        update_disable_bit <= req.dat[CTL_UPDATE_DISABLE_BIT_BIT];
      end
      if (wr_ien) begin
        int_en <= req.dat[INT_W-1:0];
      end
      if (wr_psc) begin
        prescale_value <= merge16(prescale_value, req.dat, req.sel);
      end
      if (wr_car) begin
        reload_pending <= merge16(reload_pending, req.dat, req.sel);
      end
    end
  end

  // Flags.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_flag <= '0;
    end else begin
      int_flag <= next_int_flag;
    end
  end

  // ----------------------------------------
  // Read path and outputs
  // ----------------------------------------
  // Unmapped and write-only offsets read as zero; the bus never errors.
  wire [31:0] rd_mux =
      (req.adr == OFS_CTL0)  ? {30'h0, update_disable_bit, count_enable_bit} :
      (req.adr == OFS_INTEN) ? {30'h0, int_en} :
      (req.adr == OFS_INTF)  ? {30'h0, int_flag} :
      (req.adr == OFS_CNT)   ? {16'h0000, cnt} :
      (req.adr == OFS_PSC)   ? {16'h0000, prescale_value} :
      (req.adr == OFS_CAR)   ? {16'h0000, reload_pending} :
                               ZERO_W;

  // Ack for one cycle; read data registered with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      rdata    <= ZERO_W;
      update_o <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      ack      <= access;
      rdata    <= (access && !req.we) ? rd_mux : ZERO_W;
      update_o <= update_ev;
      irq_o    <= |(next_int_flag & int_en);
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign count_o  = cnt;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wrap_zero_a : assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !wr_cnt |=> cnt == RST_CNT) else $error("counter did not wrap to zero");
  count_up_a : assert property (@(posedge clk_i) disable iff (rst_i)
    divided_count_clock && !overflow && !force_update_bit && !wr_cnt
    |=> cnt == $past(cnt) + ONE_CNT) else $error("counter did not step up");
  frozen_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !count_enable_bit && !wr_evg && !wr_cnt |=> $stable(cnt) && $stable(psc_cnt))
    else $error("disabled counter moved");
  force_upd_a : assert property (@(posedge clk_i) disable iff (rst_i)
    force_update_bit |=> cnt == RST_CNT) else $error("forced update did not clear counter");
  upd_gate_a : assert property (@(posedge clk_i) disable iff (rst_i)
    update_disable_bit |=> !update_o && $stable(psc_shadow) && $stable(reload_shadow))
    else $error("update escaped while disabled");
  ovf_upd_a : assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !update_disable_bit |=> update_o) else $error("overflow gave no update");
  shadow_a : assert property (@(posedge clk_i) disable iff (rst_i)
    update_ev |=> psc_shadow == $past(prescale_value) && reload_shadow == $past(reload_pending))
    else $error("shadow copy missing");
  psc_div_a : assert property (@(posedge clk_i) disable iff (rst_i)
    count_enable_bit && !force_update_bit && psc_cnt != psc_shadow
    |=> psc_cnt == $past(psc_cnt) + ONE_CNT) else $error("prescaler did not advance");
  flag_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    int_flag[INT_UP_BIT] && !wr_clr |=> int_flag[INT_UP_BIT]) else $error("update flag lost");
  irq_lvl_a : assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(int_flag & $past(int_en))) else $error("interrupt level wrong");

  // ----------------------------------------
  // Bus assertions
  // ----------------------------------------
  // Low half of the write data, named so that its past value can be sampled.
  wire [CNT_W-1:0] wr_half = req.dat[CNT_W-1:0];

  // Ack is a single-cycle pulse, so a request held past its ack is taken again one cycle later.
  ack_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held for more than one cycle");
  // Every new request is answered on the next edge; there are no wait states.
  ack_next_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
  // Read data is zero outside the ack cycle, so stale values never leak.
  dat_idle_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == ZERO_W) else $error("read data outside ack");
  // A write answer carries no data.
  dat_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_we_i) |-> wb_dat_o == ZERO_W) else $error("write returned data");

  // ----------------------------------------
  // Counter assertions
  // ----------------------------------------
  // Left alone, the counter never steps backwards.
  up_only_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !overflow && !force_update_bit && !wr_cnt |=> cnt >= $past(cnt))
    else $error("counter moved down");
  // Between divided ticks the counter holds, so it only moves at the prescaled rate.
  cnt_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    count_enable_bit && !divided_count_clock && !force_update_bit && !wr_cnt |=> $stable(cnt))
    else $error("counter moved between ticks");
  // The prescaler never runs past its active limit, so a tick cannot be skipped.
  psc_bound_a : assert property (@(posedge clk_i) disable iff (rst_i)
    psc_cnt <= psc_shadow) else $error("prescaler beyond its limit");
  // The prescaler restarts from zero after each divided tick.
  psc_wrap_a : assert property (@(posedge clk_i) disable iff (rst_i)
    divided_count_clock |=> psc_cnt == RST_CNT) else $error("prescaler did not restart");
  // Setting the enable bit starts the counting clock on the next cycle.
  ctl_en_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl && req.dat[CTL_CEN_BIT] |=> count_enable_bit) else $error("enable write lost");
  // The prescaler restarts on a forced update too, so the new period starts cleanly.
  force_psc_a : assert property (@(posedge clk_i) disable iff (rst_i)
    force_update_bit |=> psc_cnt == RST_CNT) else $error("forced update kept prescaler");
  // A disabled update still clears the counter but gives no pulse.
  dis_force_a : assert property (@(posedge clk_i) disable iff (rst_i)
    force_update_bit && update_disable_bit |=> cnt == RST_CNT && !update_o)
    else $error("disabled forced update misbehaved");
  // Stopped and not forced, the timer raises no update pulse.
  idle_quiet_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !count_enable_bit && !force_update_bit |=> !update_o) else $error("update while stopped");
  // Every update pulse has an overflow or a forced update behind it.
  upd_cause_a : assert property (@(posedge clk_i) disable iff (rst_i)
    update_o |-> $past(overflow) || $past(force_update_bit)) else $error("update without cause");
  // Shadow values move only on an update event; preload writes alone do nothing.
  shadow_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    !update_ev |=> $stable(psc_shadow) && $stable(reload_shadow))
    else $error("shadow moved without update");
  // A full-width prescaler write lands in the preload stage.
  psc_load_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_psc && req.sel == 4'hF |=> prescale_value == $past(wr_half))
    else $error("prescaler preload write lost");
  // A full-width reload write lands in the preload stage.
  car_load_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_car && req.sel == 4'hF |=> reload_pending == $past(wr_half))
    else $error("reload preload write lost");
  // A counter write wins over a tick; a forced update would win over the write.
  cnt_load_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cnt && !force_update_bit && req.sel == 4'hF |=> cnt == $past(wr_half))
    else $error("counter write lost");
  // Counter reads return the value held on the taking edge.
  cnt_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFS_CNT
    |-> wb_dat_o == {16'h0000, $past(cnt)}) else $error("counter read wrong");

  // ----------------------------------------
  // Flag and interrupt assertions
  // ----------------------------------------
  // Each update event leaves the update flag set, even against a clear.
  flag_set_a : assert property (@(posedge clk_i) disable iff (rst_i)
    update_ev |=> int_flag[INT_UP_BIT]) else $error("update flag not set");
  // Writing one clears the flag when no event collides with it.
  flag_clr_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wr_clr && req.dat[INT_UP_BIT] && !update_ev |=> !int_flag[INT_UP_BIT])
    else $error("update flag not cleared");
  // With updates disabled the update flag cannot be raised.
  dis_flag_a : assert property (@(posedge clk_i) disable iff (rst_i)
    update_disable_bit && !int_flag[INT_UP_BIT] |=> !int_flag[INT_UP_BIT])
    else $error("update flag set while disabled");
  // A channel event sets its flag, which then sticks until cleared.
  chan_set_a : assert property (@(posedge clk_i) disable iff (rst_i)
    chan_event_i |=> int_flag[INT_CH_BIT]) else $error("channel flag not set");
  chan_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
    int_flag[INT_CH_BIT] && !wr_clr |=> int_flag[INT_CH_BIT]) else $error("channel flag lost");
  // With no source enabled the interrupt line stays low.
  irq_mask_a : assert property (@(posedge clk_i) disable iff (rst_i)
    int_en == '0 |=> !irq_o) else $error("masked interrupt raised");
  // Flag reads return the flags held on the taking edge.
  flag_read_a : assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFS_INTF
    |-> wb_dat_o == {30'h0, $past(int_flag)}) else $error("flag read wrong");

endmodule

`default_nettype wire

/* verif/tb.sv */
// Purpose : Self-checking bench for the up-count timer base.
// Assumes : Wishbone slave acks one cycle after the taking edge.
// Notes   : Expected read values are queued by the driver and checked on ack.
`timescale 1ns/1ps
`default_nettype none

module tb
  import utb_pkg::*;
;
  logic           clk_i;
  logic           rst_i;
  logic           chan_event_i;
  utb_wb_req_type req;
  wire logic [31:0]      wb_dat_o;
  wire logic             wb_ack_o;
  wire logic             update_o;
  wire logic [CNT_W-1:0] count_o;
  wire logic             irq_o;
  int          fail_count = 0;
  int          num_checks = 0;
  int          seed = 49069;
  logic [31:0] exp_q[$];
  logic [15:0] car;
  logic [15:0] snap;
  int          p;

  utb_timer utb_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_event_i(chan_event_i),
    .update_o(update_o), .count_o(count_o), .irq_o(irq_o)
  );

  // ----------------------------------------
  // Clock, checking and closing.
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The oldest queued note is matched against read data at each read ack.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && req.we === 1'b0) begin
      if (exp_q.size() == 0) chk(wb_dat_o, 32'hDEAD_BEEF);
      else chk(wb_dat_o, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // Bus and timing helpers.
  // ----------------------------------------
  // Request is held until ack is sampled high, then released for a cycle.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, ZERO_W);
  endtask

  task automatic idle(input int n, output int pulses);
    pulses = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (update_o === 1'b1) pulses++;
    end
  endtask

  // Gap between the second and third update pulses; the first may still use old
  // shadow values when a preload write meets an update. A missing pulse ends the run.
  task automatic meas(input int want);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (update_o !== 1'b1 && n < 4000);
      if (n >= 4000) begin
        fail_count++;
        finish_test();
      end
    end
    chk(32'(n), 32'(want));
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    req = '0;
    rst_i = 1'b1;
    chan_event_i = 1'b0;
    car = 16'(2 + ($unsigned($random(seed)) % 8));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CAR, {16'h0000, RST_CAR});
    rd(OFS_PSC, ZERO_W);
    rd(OFS_CNT, ZERO_W);
    rd(OFS_INTF, ZERO_W);
    rd(8'h40, ZERO_W);
    wb(1'b1, OFS_CAR, {16'h0000, car});
    wb(1'b1, OFS_SWEVG, 32'h0000_0001);
    wb(1'b1, OFS_CTL0, 32'h0000_0001);
    meas(car + 1);
    wb(1'b1, OFS_PSC, 32'h0000_0002);
    meas(3 * (car + 1));
    wb(1'b1, OFS_CTL0, ZERO_W);
    @(posedge clk_i); // The enable drops on the ack edge, which may still tick once.
    snap = count_o;
    idle(40, p);
    chk(32'(p), ZERO_W);
    chk({16'h0000, count_o}, {16'h0000, snap});
    wb(1'b1, OFS_INTCLR, 32'h0000_0003);
    wb(1'b1, OFS_CTL0, 32'h0000_0003);
    idle(8 * (car + 1), p);
    chk(32'(p), ZERO_W);
    rd(OFS_INTF, ZERO_W);
    wb(1'b1, OFS_CTL0, ZERO_W);
    wb(1'b1, OFS_SWEVG, 32'h0000_0001);
    rd(OFS_CNT, ZERO_W);
    rd(OFS_INTF, 32'h0000_0001);
    wb(1'b1, OFS_INTEN, 32'h0000_0001);
    idle(2, p);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, OFS_INTCLR, 32'h0000_0001);
    idle(2, p);
    chk({31'h0, irq_o}, ZERO_W);
    @(posedge clk_i);
    chan_event_i <= 1'b1;
    @(posedge clk_i);
    chan_event_i <= 1'b0;
    wb(1'b1, OFS_INTEN, 32'h0000_0002);
    idle(2, p);
    chk({31'h0, irq_o}, 32'h1);
    rd(OFS_INTF, 32'h0000_0002);
    wb(1'b1, OFS_INTEN, ZERO_W);
    idle(2, p);
    chk({31'h0, irq_o}, ZERO_W);
    finish_test();
  end
endmodule

`default_nettype wire
